// ### rtl/spi_flags_regs.svh
// Register indices, field positions, reset values and timing counts
`ifndef SPI_FLAGS_REGS_SVH
`define SPI_FLAGS_REGS_SVH
// Register indices; byte address is four times the index
`define IDX_CTRL 6'h00
`define IDX_IRQ_EN 6'h02
`define IDX_IRQ_FLAGS 6'h03
`define IDX_DATA 6'h04
// Control register fields
`define CTRL_ENABLE 0
`define CTRL_SEL_DIS 2
`define CTRL_MASTER 5
`define CTRL_BUF_EN 7
// Enable and flag bit positions
`define BIT_RX_DONE 7
`define BIT_TX_DONE 6
`define BIT_TX_EMPTY 5
`define BIT_SEL_TRIG 4
`define BIT_OVF 0
`define BIT_UNBUF_EN 0
// Reset values
`define RST_BYTE 8'h00
`define SYNC_INIT 4'h8
// Timing: clock cycles per half serial clock in master operation; then the receive stage count
`define SCK_HALF_DEF 8
`define RX_STAGES 2'd2
`endif

// ### rtl/spi_flags_pkg.sv
// Types shared by the serial port modules
package spi_flags_pkg;
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_MASTER = 2'b01,
    ENG_SLAVE = 2'b10
  } eng_state_t;
endpackage : spi_flags_pkg

// ### rtl/spi_eng_if.sv
// Link between register core and shift engine
`timescale 1ns/1ns
`default_nettype none
interface spi_eng_if;
  logic load;
  logic [7:0] tx_byte;
  logic master;
  logic en;
  logic idle;
  logic done;
  logic [7:0] rx_byte;
  modport core (output load, tx_byte, master, en, input idle, done, rx_byte);
  modport eng (input load, tx_byte, master, en, output idle, done, rx_byte);
endinterface : spi_eng_if
`default_nettype wire

// ### rtl/spi_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module spi_pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw and filtered levels
  input wire logic [W-1:0] d_i,
  output var logic [W-1:0] q_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // =====================================
  // Chain; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q_o <= INIT;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      // A bit only moves once stages two and three agree
      q_o <= (s3 & ~(s2 ^ s3)) | (q_o & (s2 ^ s3));
    end
  end
endmodule : spi_pin_sync
`default_nettype wire

// ### rtl/spi_shift_engine.sv
// Byte shifter for master and slave operation, mode 0, MSB first
`timescale 1ns/1ns
`default_nettype none
`include "spi_flags_regs.svh"
module spi_shift_engine import spi_flags_pkg::*; #(
  parameter int SCK_HALF = `SCK_HALF_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Core side
  spi_eng_if.eng eng,
  // Filtered pin levels
  input wire logic sck_s_i,
  input wire logic mosi_s_i,
  input wire logic miso_s_i,
  input wire logic ss_n_s_i,
  // Pin drivers
  output var logic sck_o,
  output var logic sck_oe_o,
  output var logic mosi_o,
  output var logic mosi_oe_o,
  output var logic miso_o,
  output var logic miso_oe_o
);
  localparam int DW = $clog2(SCK_HALF + 1);
  eng_state_t state;
  logic [DW-1:0] div;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic [7:0] rxsh;
  logic sck_p;
  logic tick;
  logic s_rise;
  logic s_fall;

  // =====================================
  // Edge and rate detection
  assign tick = (div == DW'(SCK_HALF - 1));
  assign s_rise = sck_s_i & ~sck_p;
  assign s_fall = ~sck_s_i & sck_p;
  assign eng.idle = (state != ENG_MASTER) && (cnt == 4'd0);

  // Half-period divider, only runs while mastering
  always_ff @(posedge clk_i) begin
    if (rst_i || state != ENG_MASTER || tick) begin
      div <= '0;
    end else begin
      div <= div + DW'(1);
    end
  end

  // Previous filtered clock level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_p <= 1'b0;
    end else begin
      sck_p <= sck_s_i;
    end
  end

  // Drive enables follow the selected role
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_oe_o <= 1'b0;
      mosi_oe_o <= 1'b0;
      miso_oe_o <= 1'b0;
    end else begin
      sck_oe_o <= eng.en & eng.master;
      mosi_oe_o <= eng.en & eng.master;
      miso_oe_o <= (state == ENG_SLAVE);
    end
  end

  // =====================================
  // Shift state machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ENG_IDLE;
      cnt <= 4'd0;
      shreg <= `RST_BYTE;
      rxsh <= `RST_BYTE;
      sck_o <= 1'b0;
      mosi_o <= 1'b0;
      miso_o <= 1'b0;
      eng.done <= 1'b0;
      eng.rx_byte <= `RST_BYTE;
    end else begin
      eng.done <= 1'b0;
      unique case (state)
        ENG_IDLE: begin
          cnt <= 4'd0;
          if (eng.load && eng.master) begin
            shreg <= eng.tx_byte;
            mosi_o <= eng.tx_byte[7];
            state <= ENG_MASTER;
          end else begin
            if (eng.load) begin
              shreg <= eng.tx_byte;
              miso_o <= eng.tx_byte[7];
            end
            if (eng.en && !eng.master && !ss_n_s_i) begin
              state <= ENG_SLAVE;
            end
          end
        end
        ENG_MASTER: begin
          // Losing the master role aborts the byte in flight
          if (!eng.master || !eng.en) begin
            state <= ENG_IDLE;
            sck_o <= 1'b0;
          end else if (tick && !sck_o) begin
            sck_o <= 1'b1;
            rxsh <= {rxsh[6:0], miso_s_i};
            cnt <= cnt + 4'd1;
          end else if (tick) begin
            sck_o <= 1'b0;
            if (cnt == 4'd8) begin
              eng.done <= 1'b1;
              eng.rx_byte <= rxsh;
              state <= ENG_IDLE;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              mosi_o <= shreg[6];
            end
          end
        end
        ENG_SLAVE: begin
          if (ss_n_s_i || eng.master || !eng.en) begin
            state <= ENG_IDLE;
            cnt <= 4'd0;
          end else begin
            if (eng.load && cnt == 4'd0) begin
              shreg <= eng.tx_byte;
              miso_o <= eng.tx_byte[7];
            end
            if (s_rise) begin
              rxsh <= {rxsh[6:0], mosi_s_i};
              if (cnt == 4'd7) begin
                eng.done <= 1'b1;
                eng.rx_byte <= {rxsh[6:0], mosi_s_i};
                cnt <= 4'd0;
              end else begin
                cnt <= cnt + 4'd1;
              end
            end
            if (s_fall && cnt != 4'd0) begin
              shreg <= {shreg[6:0], 1'b0};
              miso_o <= shreg[6];
            end
          end
        end
        default: state <= ENG_IDLE;
      endcase
    end
  end
endmodule : spi_shift_engine
`default_nettype wire

// ### rtl/spi_irq_flags_port.sv
// Serial port register core: interrupt enables, flags and data port
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "spi_flags_regs.svh"

// What this block does
// - Buffered: receive-done enable routes its flag to the interrupt; reads zero unbuffered
// - Buffered: transfer-done enable routes its flag; reads zero unbuffered
// - Buffered: buffer-empty enable routes its flag; reads zero unbuffered
// - Buffered: select-trigger enable routes its flag; reads zero unbuffered
// - Unbuffered: general enable routes the combined transfer flag to the interrupt
// - Buffered: receive-done flag high while receive stages hold unread bytes
// - Writing one to the receive-done flag clears it
// - Unbuffered: transfer flag set on byte done or select low as master
// - Transfer flag cleared by vector taken or flags read then data access
// - Buffered: transfer-done set when shifter and buffer are empty; write one clears
// - Unbuffered: data write during a byte sets collision; flags read then data clears
// - Buffer-empty flag set when the transmit buffer drains into the shifter; zero unbuffered
// - Data write clears buffer-empty; enabled flag keeps interrupt asserted
// - Buffered: master forced to slave by select low sets select-trigger; write one clears
// - Buffered: overflow set when two stages full and a third byte completes
// - Overflow only on completed transfers, held until data is read
// - Writing the data register starts shifting the byte out
// - Buffered data read returns stage two and moves stage one up
// - Buffered-mode bit selects two receive stages and one transmit stage
// - Interrupt stays asserted while any enabled flag remains set
// - Select low as master without disable drops master and sets transfer flag
module spi_irq_flags_port import spi_flags_pkg::*; #(
  parameter int SCK_HALF = `SCK_HALF_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output var logic [31:0] dat_o,
  output var logic ack_o,
  // Interrupt
  output var logic irq_o,
  input wire logic vector_taken_i,
  // Serial pins
  input wire logic sck_i,
  output var logic sck_o,
  output var logic sck_oe_o,
  input wire logic mosi_i,
  output var logic mosi_o,
  output var logic mosi_oe_o,
  input wire logic miso_i,
  output var logic miso_o,
  output var logic miso_oe_o,
  input wire logic ss_n_i
);
  spi_eng_if eng ();
  logic [3:0] pins;
  // Control state
  logic enable;
  logic master;
  logic select_disable;
  logic buffered_mode_en;
  // Interrupt enables
  logic rx_done_irq_en;
  logic tx_done_irq_en;
  logic tx_empty_irq_en;
  logic select_trig_irq_en;
  logic unbuffered_irq_en;
  // Flags
  logic rx_done_flag;
  logic tx_done_flag;
  logic tx_empty_flag;
  logic select_trig_flag;
  logic rx_overflow_flag;
  logic xfer_flag;
  logic write_collision_flag;
  logic arm_xfer;
  logic arm_wcol;
  // Data path
  logic [7:0] rx_near;
  logic [7:0] rx_far;
  logic [1:0] rx_cnt;
  logic [7:0] tx_buf;
  logic tx_full;
  // Decoded strobes
  logic acc;
  logic wr;
  logic rd;
  logic ctrl_wr;
  logic en_wr;
  logic flags_wr;
  logic flags_rd;
  logic data_wr;
  logic data_rd;
  logic data_acc;
  logic trig;
  logic pop;
  logic push;
  logic ovf_set;
  logic [1:0] slot;
  logic next_irq;
  logic [7:0] next_rd;
  logic [7:0] en_view;
  logic [7:0] flag_view;

  function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
    return a[7:2] == idx;
  endfunction : hit

  // =====================================
  // Pins and shift engine
  spi_pin_sync #(.W(4), .INIT(`SYNC_INIT)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({ss_n_i, miso_i, mosi_i, sck_i}),
    .q_o(pins)
  );

  spi_shift_engine #(.SCK_HALF(SCK_HALF)) u_eng (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .eng(eng.eng),
    .sck_s_i(pins[0]),
    .mosi_s_i(pins[1]),
    .miso_s_i(pins[2]),
    .ss_n_s_i(pins[3]),
    .sck_o(sck_o),
    .sck_oe_o(sck_oe_o),
    .mosi_o(mosi_o),
    .mosi_oe_o(mosi_oe_o),
    .miso_o(miso_o),
    .miso_oe_o(miso_oe_o)
  );

  // =====================================
  // Bus decode; side effects land on the edge that raises ack
  assign acc = cyc_i & stb_i & ~ack_o;
  assign wr = acc & we_i & sel_i[0];
  assign rd = acc & ~we_i;
  assign ctrl_wr = wr & hit(adr_i, `IDX_CTRL);
  assign en_wr = wr & hit(adr_i, `IDX_IRQ_EN);
  assign flags_wr = wr & hit(adr_i, `IDX_IRQ_FLAGS);
  assign flags_rd = rd & hit(adr_i, `IDX_IRQ_FLAGS);
  assign data_wr = wr & hit(adr_i, `IDX_DATA);
  assign data_rd = rd & hit(adr_i, `IDX_DATA);
  assign data_acc = data_wr | data_rd;

  // Engine requests: direct start unbuffered, buffer drain when buffered
  assign eng.master = master;
  assign eng.en = enable;
  assign eng.load = enable & eng.idle &
                    (buffered_mode_en ? tx_full : (data_wr & ~pins[3] | data_wr & master));
  assign eng.tx_byte = buffered_mode_en ? tx_buf : dat_i[7:0];

  // Select pulled low while mastering
  assign trig = enable & master & ~select_disable & ~pins[3];

  // Receive stage bookkeeping
  assign pop = buffered_mode_en & data_rd & (rx_cnt != 2'd0);
  assign push = buffered_mode_en & eng.done & ((rx_cnt != `RX_STAGES) | pop);
  assign ovf_set = buffered_mode_en & eng.done & (rx_cnt == `RX_STAGES) & ~pop;
  assign slot = rx_cnt - {1'b0, pop};

  // Views that hide the other mode's bits, except the unbuffered enable still shown at bit 0 when buffered
  assign en_view = buffered_mode_en ?
    {rx_done_irq_en, tx_done_irq_en, tx_empty_irq_en, select_trig_irq_en, 3'h0,
     unbuffered_irq_en} : {7'h00, unbuffered_irq_en};
  assign flag_view = buffered_mode_en ?
    {rx_done_flag, tx_done_flag, tx_empty_flag, select_trig_flag, 3'h0,
     rx_overflow_flag} : {xfer_flag, write_collision_flag, 6'h00};

  // Interrupt combine for the current mode
  always_comb begin
    if (buffered_mode_en) begin
      next_irq = |({rx_done_irq_en, tx_done_irq_en, tx_empty_irq_en, select_trig_irq_en} &
                   {rx_done_flag, tx_done_flag, tx_empty_flag, select_trig_flag});
    end else begin
      next_irq = unbuffered_irq_en & xfer_flag;
    end
  end

  // Read mux
  always_comb begin
    next_rd = 8'h00;
    if (hit(adr_i, `IDX_CTRL)) begin
      next_rd = {buffered_mode_en, 1'b0, master, 2'b00, select_disable, 1'b0, enable};
    end else if (hit(adr_i, `IDX_IRQ_EN)) begin
      next_rd = en_view;
    end else if (hit(adr_i, `IDX_IRQ_FLAGS)) begin
      next_rd = flag_view;
    end else if (hit(adr_i, `IDX_DATA)) begin
      next_rd = rx_far;
    end
  end

  // =====================================
  // Bus answer: one wait-free cycle, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      irq_o <= 1'b0;
    end else begin
      ack_o <= acc;
      if (rd) begin
        dat_o <= {24'h00_0000, next_rd};
      end
      irq_o <= next_irq;
    end
  end

  // Control register; hardware drop of master beats a write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable <= 1'b0;
      master <= 1'b0;
      select_disable <= 1'b0;
      buffered_mode_en <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        enable <= dat_i[`CTRL_ENABLE];
        master <= dat_i[`CTRL_MASTER];
        select_disable <= dat_i[`CTRL_SEL_DIS];
        buffered_mode_en <= dat_i[`CTRL_BUF_EN];
      end
      if (trig) begin
        master <= 1'b0;
      end
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_done_irq_en <= 1'b0;
      tx_done_irq_en <= 1'b0;
      tx_empty_irq_en <= 1'b0;
      select_trig_irq_en <= 1'b0;
      unbuffered_irq_en <= 1'b0;
    end else if (en_wr) begin
      rx_done_irq_en <= dat_i[`BIT_RX_DONE];
      tx_done_irq_en <= dat_i[`BIT_TX_DONE];
      tx_empty_irq_en <= dat_i[`BIT_TX_EMPTY];
      select_trig_irq_en <= dat_i[`BIT_SEL_TRIG];
      unbuffered_irq_en <= dat_i[`BIT_UNBUF_EN];
    end
  end

  // =====================================
  // Buffered flags; every set is placed after its clear so it wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_done_flag <= 1'b0;
      tx_done_flag <= 1'b0;
      tx_empty_flag <= 1'b0;
      select_trig_flag <= 1'b0;
      rx_overflow_flag <= 1'b0;
    end else begin
      if ((flags_wr && dat_i[`BIT_RX_DONE]) || (pop && rx_cnt == 2'd1)) begin
        rx_done_flag <= 1'b0;
      end
      if (push) begin
        rx_done_flag <= 1'b1;
      end
      if (flags_wr && dat_i[`BIT_TX_DONE]) begin
        tx_done_flag <= 1'b0;
      end
      if (buffered_mode_en && eng.done && !tx_full) begin
        tx_done_flag <= 1'b1;
      end
      if (data_wr) begin
        tx_empty_flag <= 1'b0;
      end
      if (buffered_mode_en && eng.load) begin
        tx_empty_flag <= 1'b1;
      end
      if (flags_wr && dat_i[`BIT_SEL_TRIG]) begin
        select_trig_flag <= 1'b0;
      end
      if (buffered_mode_en && trig) begin
        select_trig_flag <= 1'b1;
      end
      // Write data for the overflow bit is ignored; software keeps it zero
      if (data_rd) begin
        rx_overflow_flag <= 1'b0;
      end
      if (ovf_set) begin
        rx_overflow_flag <= 1'b1;
      end
    end
  end

  // Unbuffered flags with read-then-access clearing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xfer_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      arm_xfer <= 1'b0;
      arm_wcol <= 1'b0;
    end else begin
      if (flags_rd) begin
        arm_xfer <= xfer_flag;
        arm_wcol <= write_collision_flag;
      end
      if (vector_taken_i || (data_acc && arm_xfer)) begin
        xfer_flag <= 1'b0;
        arm_xfer <= 1'b0;
      end
      if (data_acc && arm_wcol) begin
        write_collision_flag <= 1'b0;
        arm_wcol <= 1'b0;
      end
      if ((!buffered_mode_en && eng.done) || trig) begin
        xfer_flag <= 1'b1;
      end
      // A collision write is dropped; the byte in flight continues
      if (!buffered_mode_en && data_wr && !eng.idle) begin
        write_collision_flag <= 1'b1;
      end
    end
  end

  // =====================================
  // Transmit buffer, one stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_buf <= `RST_BYTE;
      tx_full <= 1'b0;
    end else begin
      if (buffered_mode_en && eng.load) begin
        tx_full <= 1'b0;
      end
      if (buffered_mode_en && data_wr) begin
        tx_buf <= dat_i[7:0];
        tx_full <= 1'b1;
      end
    end
  end

  // Receive stages; a pop moves stage one into stage two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_near <= `RST_BYTE;
      rx_far <= `RST_BYTE;
      rx_cnt <= 2'd0;
    end else if (buffered_mode_en) begin
      if (pop) begin
        rx_far <= rx_near;
      end
      if (push && slot == 2'd0) begin
        rx_far <= eng.rx_byte;
      end
      if (push && slot == 2'd1) begin
        rx_near <= eng.rx_byte;
      end
      rx_cnt <= slot + {1'b0, push};
    end else begin
      rx_cnt <= 2'd0;
      if (eng.done) begin
        rx_far <= eng.rx_byte;
      end
    end
  end

  // =====================================
  // Checks
  property p_rx_irq;
    @(posedge clk_i) disable iff (rst_i)
    buffered_mode_en && rx_done_irq_en && rx_done_flag |=> irq_o;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("receive irq missing");

  property p_txd_irq;
    @(posedge clk_i) disable iff (rst_i)
    buffered_mode_en && tx_done_irq_en && tx_done_flag |=> irq_o;
  endproperty
  a_txd_irq: assert property (p_txd_irq) else $error("transfer irq missing");

  property p_unbuf_irq;
    @(posedge clk_i) disable iff (rst_i)
    !buffered_mode_en && $rose(xfer_flag) && unbuffered_irq_en && !en_wr && !ctrl_wr
    |=> irq_o;
  endproperty
  a_unbuf_irq: assert property (p_unbuf_irq) else $error("unbuffered irq missing");

  property p_push_flag;
    @(posedge clk_i) disable iff (rst_i)
    buffered_mode_en && eng.done && rx_cnt == 2'd0 |=> rx_done_flag && rx_cnt == 2'd1;
  endproperty
  a_push_flag: assert property (p_push_flag) else $error("receive flag not set");

  property p_ovf;
    @(posedge clk_i) disable iff (rst_i)
    ovf_set |=> rx_overflow_flag && rx_cnt == 2'd2;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged");

  property p_wr_clears_empty;
    @(posedge clk_i) disable iff (rst_i)
    data_wr && !(buffered_mode_en && eng.load) |=> !tx_empty_flag;
  endproperty
  a_wr_clears_empty: assert property (p_wr_clears_empty) else $error("empty not cleared");

  property p_trig;
    @(posedge clk_i) disable iff (rst_i)
    trig |=> !master && xfer_flag;
  endproperty
  a_trig: assert property (p_trig) else $error("select trigger missed");

  property p_wcol;
    @(posedge clk_i) disable iff (rst_i)
    !buffered_mode_en && data_wr && !eng.idle |=> write_collision_flag;
  endproperty
  a_wcol: assert property (p_wcol) else $error("collision not flagged");

  property p_pop;
    @(posedge clk_i) disable iff (rst_i)
    pop && !push |=> rx_cnt == $past(rx_cnt) - 2'd1;
  endproperty
  a_pop: assert property (p_pop) else $error("receive stage not popped");
endmodule : spi_irq_flags_port
`default_nettype wire

// ### tb/spi_peer_model.sv
// Behavioural far-side serial device, mode 0, most significant bit first
`timescale 1ns/1ns
`default_nettype none
module spi_peer_model (
  // Serial lines as seen on the wires
  input wire logic sck_i,
  input wire logic mosi_i,
  // Byte to send, byte last received
  input wire logic [7:0] load_i,
  output var logic miso_o,
  output var logic [7:0] got_o
);
  logic [7:0] rx;
  logic [7:0] tx;
  int n;
  initial begin
    rx = 8'h00;
    tx = 8'h00;
    n = 0;
    got_o = 8'h00;
    miso_o = 1'b0;
  end
  // Sample on the rising edge; the frame byte is latched on its first rise
  always @(posedge sck_i) begin
    if (n == 0) begin
      tx = load_i;
    end
    rx = {rx[6:0], mosi_i};
    n = n + 1;
    if (n == 8) begin
      got_o = rx;
      n = 0;
    end
  end
  // Change on the falling edge, or on a new load between frames, so the master never samples a moving bit
  always @(negedge sck_i) begin
    miso_o = (n == 0) ? load_i[7] : tx[7 - n];
  end
  always @(load_i) begin
    if (n == 0) begin
      miso_o = load_i[7];
    end
  end
endmodule : spi_peer_model
`default_nettype wire

// ### tb/spi_irq_flags_port_tb_top.sv
// Self-checking bench for the serial port register core
`timescale 1ns/1ns
`default_nettype none
module spi_irq_flags_port_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, vec = 1'b0, ss_n = 1'b1;
  logic [7:0] adr = 8'h00, wdat = 8'h00, rdat = 8'h00, load = 8'h00, d, p, b0, b1, peer_rx;
  logic [31:0] dat_o;
  logic ack_o, irq_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, peer_miso;
  logic [8:0] notes[$];
  int n_errors = 0, comparisons = 0, seed = 32'h5ad0e63a;
  // Wire levels: released sck and mosi are pulled low; released miso carries the peer
  wire sck_w = sck_oe_o ? sck_o : 1'b0;
  wire mosi_w = mosi_oe_o ? mosi_o : 1'b0;
  wire miso_w = miso_oe_o ? miso_o : peer_miso;

  spi_irq_flags_port i_spi_irq_flags_port (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i({24'h000000, wdat}),
    .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .vector_taken_i(vec), .sck_i(sck_w),
    .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe_o(mosi_oe_o), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
    .ss_n_i(ss_n));
  spi_peer_model i_spi_peer_model (.sck_i(sck_w), .mosi_i(mosi_w), .load_i(load),
    .miso_o(peer_miso), .got_o(peer_rx));

  // ==========================================
  // Clock, checks and verdict
  always #2 clk_i = ~clk_i;
  task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, s);
    end
  endtask : cmp_byte
  task automatic cmp_bit(input string what, input logic e, input logic s);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s: expected %b seen %b", what, e, s);
    end
  endtask : cmp_bit
  task automatic give_verdict;
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // Read data is judged at the ack edge against the oldest note
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && cyc === 1'b1 && we === 1'b0 && notes.size() > 0) begin
      if (notes[0][8]) cmp_byte("read data", notes[0][7:0], dat_o[7:0]);
      void'(notes.pop_front());
    end
  end
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end

  // ==========================================
  // Wishbone classic single cycles; the request holds until ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rdat = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic care);
    notes.push_back({care, e});
    wb(1'b0, a, 8'h00);
  endtask : rd
  task automatic wait_flag(input int b);
    rdat = 8'h00;
    for (int i = 0; i < 100 && rdat[b] !== 1'b1; i++) rd(8'h0c, 8'h00, 1'b0);
    cmp_bit("flag seen", 1'b1, rdat[b]);
  endtask : wait_flag
  task automatic send(input logic [7:0] v);
    load <= 8'($random(seed));
    wb(1'b1, 8'h10, v);
  endtask : send

  // ==========================================
  // Scenarios
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 2; i < 5; i++) rd(8'(i * 4), 8'h00, 1'b1);
    rd(8'h0c, 8'h00, 1'b1);
    wb(1'b1, 8'h00, 8'h21);
    wb(1'b1, 8'h08, 8'hf1);
    rd(8'h08, 8'h01, 1'b1);
    d = 8'($random(seed));
    send(d);
    p = load;
    wb(1'b1, 8'h10, ~d);
    for (int i = 0; i < 400 && irq_o !== 1'b1; i++) @(posedge clk_i);
    cmp_bit("irq", 1'b1, irq_o);
    rd(8'h0c, 8'hc0, 1'b1);
    rd(8'h10, p, 1'b1);
    cmp_byte("peer byte", d, peer_rx);
    rd(8'h0c, 8'h00, 1'b1);
    cmp_bit("irq", 1'b0, irq_o);
    send(8'h3c);
    wait_flag(7);
    vec <= 1'b1;
    @(posedge clk_i);
    vec <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(8'h0c, 8'h00, 1'b1);
    ss_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(8'h0c, 8'h80, 1'b1);
    rd(8'h00, 8'h01, 1'b1);
    cmp_bit("sck drive", 1'b0, sck_oe_o);
    cmp_bit("miso drive", 1'b1, miso_oe_o);
    ss_n <= 1'b1;
    rd(8'h10, 8'h00, 1'b0);
    wb(1'b1, 8'h00, 8'ha1);
    wb(1'b1, 8'h08, 8'hf0);
    rd(8'h08, 8'hf0, 1'b1);
    for (int k = 0; k < 3; k++) begin
      send(8'($random(seed)));
      if (k == 0) b0 = load;
      if (k == 1) b1 = load;
      wait_flag(6);
      wb(1'b1, 8'h0c, 8'h40);
    end
    rd(8'h0c, 8'ha1, 1'b1);
    cmp_bit("irq", 1'b1, irq_o);
    rd(8'h10, b0, 1'b1);
    rd(8'h10, b1, 1'b1);
    rd(8'h0c, 8'h20, 1'b1);
    ss_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(8'h0c, 8'h30, 1'b1);
    wb(1'b1, 8'h0c, 8'h10);
    rd(8'h0c, 8'h20, 1'b1);
    ss_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    give_verdict();
  end
endmodule : spi_irq_flags_port_tb_top
`default_nettype wire
